// ---- pmicf_pkg.sv ----
// constants and types shared by the interrupt flag block and its serial slave
package pmicf_pkg;

    // serial slave address: 0xC0 write, 0xC1 read
    localparam logic [6:0] PMICF_DEV_ADDR      = 7'h60;

    // register offsets
    localparam logic [7:0] PMICF_ADDR_SOURCE   = 8'h00;
    localparam logic [7:0] PMICF_ADDR_THERMAL  = 8'h01;
    localparam logic [7:0] PMICF_ADDR_REG_LOW  = 8'h02;
    localparam logic [7:0] PMICF_ADDR_REG_HIGH = 8'h03;
    localparam logic [7:0] PMICF_ADDR_UPDOWN   = 8'h04;
    localparam logic [7:0] PMICF_ADDR_THM_MASK = 8'h06;
    localparam logic [7:0] PMICF_ADDR_RL_MASK  = 8'h07;
    localparam logic [7:0] PMICF_ADDR_RH_MASK  = 8'h08;
    localparam logic [7:0] PMICF_ADDR_UD_MASK  = 8'h09;

    // reset values
    localparam logic [7:0] PMICF_FLAG_RESET    = 8'h00;
    localparam logic [7:0] PMICF_THM_MASK_RST  = 8'h03;
    localparam logic [7:0] PMICF_REG_MASK_RST  = 8'hFF;
    localparam logic [7:0] PMICF_UD_MASK_RST   = 8'h07;

    // implemented bits of the narrow registers, the rest read as zero
    localparam logic [7:0] PMICF_THM_FIELD     = 8'h03;
    localparam logic [7:0] PMICF_UD_FIELD      = 8'h07;

    // bit positions
    localparam int PMICF_SRC_THERMAL_BIT = 0;
    localparam int PMICF_SRC_REG_BIT     = 1;
    localparam int PMICF_SRC_UPDOWN_BIT  = 2;
    localparam int PMICF_THM_CRIT_BIT    = 0;
    localparam int PMICF_THM_WARN_BIT    = 1;
    localparam int PMICF_STEP_DOWN_BIT   = 7;
    localparam int PMICF_UD_OCP_BIT      = 0;
    localparam int PMICF_UD_OVP_BIT      = 1;
    localparam int PMICF_UD_PG_BIT       = 2;

    // linear regulators in the low flag register, and in total
    localparam int PMICF_LINEAR_LOW      = 8;
    localparam int PMICF_LINEAR_COUNT    = 15;

    localparam logic [3:0] PMICF_LAST_BIT = 4'h7;

    typedef enum logic [2:0] {
        PMICF_IDLE,
        PMICF_ADDR,
        PMICF_ADDR_ACK,
        PMICF_WRITE,
        PMICF_WRITE_ACK,
        PMICF_READ,
        PMICF_READ_ACK
    } pmicf_i2c_state_t;

endpackage

// ---- pmicf_i2c_slave.sv ----
// two-wire serial slave: byte pointer, register writes and reads
`timescale 1ns/1ns
module pmicf_i2c_slave #(
    parameter logic [6:0] DEV_ADDR = pmicf_pkg::PMICF_DEV_ADDR
) (
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    output logic            wr_en_o,
    output logic [7:0]      wr_addr_o,
    output logic [7:0]      wr_data_o,
    output logic            rd_en_o,
    output logic [7:0]      rd_addr_o,
    input  wire logic [7:0] rd_data_i
);
    import pmicf_pkg::*;

    // elaboration check: the general call address cannot be claimed
    if (DEV_ADDR == 7'h00)
    begin : g_bad_addr
        $error("general call address cannot be the slave address");
    end

    pmicf_i2c_state_t state_q;
    logic       scl_q;
    logic       sda_q;
    logic [3:0] cnt_q;
    logic [7:0] shift_q;
    logic [7:0] ptr_q;
    logic       rw_q;
    logic       first_q;
    logic       ack_q;
    logic       oe_q;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic       load;

    assign scl_rise  = scl_i & ~scl_q;
    assign scl_fall  = ~scl_i & scl_q;
    assign start_det = scl_i & scl_q & sda_q & ~sda_i;
    assign stop_det  = scl_i & scl_q & ~sda_q & sda_i;
    // a new byte is fetched after address ack for reads and after a host ack
    assign load      = scl_fall & ((state_q == PMICF_ADDR_ACK & rw_q) | (state_q == PMICF_READ_ACK & ack_q));

    assign sda_o     = 1'b0;
    assign sda_oe_o  = oe_q;
    assign rd_en_o   = load;
    assign rd_addr_o = ptr_q;

    // ***********************************
    // line sampling
    // ***********************************
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    // ***********************************
    // protocol sequencer
    // ***********************************
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q   <= PMICF_IDLE;
            cnt_q     <= 4'h0;
            shift_q   <= 8'h00;
            ptr_q     <= 8'h00;
            rw_q      <= 1'b0;
            first_q   <= 1'b0;
            ack_q     <= 1'b0;
            oe_q      <= 1'b0;
            wr_en_o   <= 1'b0;
            wr_addr_o <= 8'h00;
            wr_data_o <= 8'h00;
        end
        else
        begin
            wr_en_o <= 1'b0;
            if (start_det)
            begin
                state_q <= PMICF_ADDR;
                cnt_q   <= 4'h0;
                oe_q    <= 1'b0;
            end
            else if (stop_det)
            begin
                state_q <= PMICF_IDLE;
                oe_q    <= 1'b0;
            end
            else if (load)
            begin
                shift_q <= rd_data_i;
                ptr_q   <= ptr_q + 8'h01;
                cnt_q   <= 4'h0;
                oe_q    <= ~rd_data_i[7];
                state_q <= PMICF_READ;
            end
            else
            begin
                case (state_q)
                    PMICF_ADDR, PMICF_WRITE:
                    begin
                        if (scl_rise)
                        begin
                            shift_q <= {shift_q[6:0], sda_i};
                            cnt_q   <= cnt_q + 4'h1;
                        end
                        else if (scl_fall && cnt_q == PMICF_LAST_BIT + 4'h1)
                        begin
                            cnt_q <= 4'h0;
                            if (state_q == PMICF_ADDR)
                            begin
                                if (shift_q[7:1] == DEV_ADDR)
                                begin
                                    oe_q    <= 1'b1;
                                    rw_q    <= shift_q[0];
                                    first_q <= ~shift_q[0];
                                    state_q <= PMICF_ADDR_ACK;
                                end
                                else
                                    state_q <= PMICF_IDLE;
                            end
                            else
                            begin
                                oe_q    <= 1'b1;
                                state_q <= PMICF_WRITE_ACK;
                                first_q <= 1'b0;
                                if (first_q)
                                    ptr_q <= shift_q;
                                else
                                begin
                                    wr_en_o   <= 1'b1;
                                    wr_addr_o <= ptr_q;
                                    wr_data_o <= shift_q;
                                    ptr_q     <= ptr_q + 8'h01;
                                end
                            end
                        end
                    end
                    PMICF_ADDR_ACK, PMICF_WRITE_ACK:
                    begin
                        if (scl_fall)
                        begin
                            oe_q    <= 1'b0;
                            state_q <= PMICF_WRITE;
                        end
                    end
                    PMICF_READ:
                    begin
                        if (scl_fall)
                        begin
                            shift_q <= {shift_q[6:0], 1'b0};
                            cnt_q   <= cnt_q + 4'h1;
                            if (cnt_q == PMICF_LAST_BIT)
                            begin
                                oe_q    <= 1'b0;
                                state_q <= PMICF_READ_ACK;
                            end
                            else
                                oe_q <= ~shift_q[6];
                        end
                    end
                    PMICF_READ_ACK:
                    begin
                        if (scl_rise)
                            ack_q <= ~sda_i;
                        else if (scl_fall)
                            state_q <= PMICF_IDLE;
                    end
                    default:
                    begin
                        oe_q <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule

// ---- pmicf_flags.sv ----
// interrupt flag registers of the power manager behind the serial slave
`timescale 1ns/1ns

module pmicf_flags (
    input  wire logic                                    core_clk_i,
    input  wire logic                                    rst_i,
    input  wire logic                                    scl_i,
    input  wire logic                                    sda_i,
    output logic                                         sda_o,
    output logic                                         sda_oe_o,
    input  wire logic                                    over_temp_warning_i,
    input  wire logic                                    over_temp_critical_i,
    input  wire logic [pmicf_pkg::PMICF_LINEAR_COUNT-1:0] linear_reg_power_good_i,
    input  wire logic                                    step_down_power_good_i,
    input  wire logic                                    updown_power_good_i,
    input  wire logic                                    updown_overvoltage_i,
    input  wire logic                                    updown_overcurrent_i,
    output logic [7:0]                                   interrupt_source_summary_o
);
    import pmicf_pkg::*;

    logic [7:0] thermal_q;
    logic [7:0] reg_low_q;
    logic [7:0] reg_high_q;
    logic [7:0] updown_q;
    logic [7:0] thm_mask_q;
    logic [7:0] rl_mask_q;
    logic [7:0] rh_mask_q;
    logic [7:0] ud_mask_q;
    logic [7:0] summary_q;
    logic [7:0] thermal_in;
    logic [7:0] reg_low_in;
    logic [7:0] reg_high_in;
    logic [7:0] updown_in;
    logic [7:0] thermal_prev_q;
    logic [7:0] reg_low_prev_q;
    logic [7:0] reg_high_prev_q;
    logic [7:0] updown_prev_q;
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic       rd_en;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;

    // ***********************************
    // helpers
    // ***********************************
    function automatic logic [7:0] rise(input logic [7:0] cur, input logic [7:0] prev);
        rise = cur & ~prev;
    endfunction

    // set wins over the read clear in the same cycle
    function automatic logic [7:0] next_flags(input logic [7:0] flags, input logic [7:0] set,
                                              input logic clr);
        next_flags = (clr ? 8'h00 : flags) | set;
    endfunction

    function automatic logic any_unmasked(input logic [7:0] flags, input logic [7:0] mask);
        any_unmasked = |(flags & ~mask);
    endfunction

    // ***********************************
    // event inputs placed at their flag bits
    // ***********************************
    always_comb
    begin
        thermal_in = 8'h00;
        updown_in  = 8'h00;
        thermal_in[PMICF_THM_WARN_BIT] = over_temp_warning_i;
        thermal_in[PMICF_THM_CRIT_BIT] = over_temp_critical_i;
        reg_low_in = linear_reg_power_good_i[PMICF_LINEAR_LOW-1:0];
        reg_high_in = {step_down_power_good_i,
                       linear_reg_power_good_i[PMICF_LINEAR_COUNT-1:PMICF_LINEAR_LOW]};
        updown_in[PMICF_UD_OCP_BIT] = updown_overcurrent_i;
        updown_in[PMICF_UD_OVP_BIT] = updown_overvoltage_i;
        updown_in[PMICF_UD_PG_BIT]  = updown_power_good_i;
    end

    // ***********************************
    // serial slave
    // ***********************************
    pmicf_i2c_slave #(
        .DEV_ADDR   (PMICF_DEV_ADDR)
    ) u_slave (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .scl_i      (scl_i),
        .sda_i      (sda_i),
        .sda_o      (sda_o),
        .sda_oe_o   (sda_oe_o),
        .wr_en_o    (wr_en),
        .wr_addr_o  (wr_addr),
        .wr_data_o  (wr_data),
        .rd_en_o    (rd_en),
        .rd_addr_o  (rd_addr),
        .rd_data_i  (rd_data)
    );

    // ***********************************
    // previous input levels for edge detection
    // ***********************************
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            thermal_prev_q  <= 8'h00;
            reg_low_prev_q  <= 8'h00;
            reg_high_prev_q <= 8'h00;
            updown_prev_q   <= 8'h00;
        end
        else
        begin
            thermal_prev_q  <= thermal_in;
            reg_low_prev_q  <= reg_low_in;
            reg_high_prev_q <= reg_high_in;
            updown_prev_q   <= updown_in;
        end
    end

    // ***********************************
    // event flags, cleared when read
    // ***********************************
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            thermal_q  <= PMICF_FLAG_RESET;
            reg_low_q  <= PMICF_FLAG_RESET;
            reg_high_q <= PMICF_FLAG_RESET;
            updown_q   <= PMICF_FLAG_RESET;
        end
        else
        begin
            thermal_q  <= next_flags(thermal_q, rise(thermal_in, thermal_prev_q),
                                     rd_en && rd_addr == PMICF_ADDR_THERMAL);
            reg_low_q  <= next_flags(reg_low_q, rise(reg_low_in, reg_low_prev_q),
                                     rd_en && rd_addr == PMICF_ADDR_REG_LOW);
            reg_high_q <= next_flags(reg_high_q, rise(reg_high_in, reg_high_prev_q),
                                     rd_en && rd_addr == PMICF_ADDR_REG_HIGH);
            updown_q   <= next_flags(updown_q, rise(updown_in, updown_prev_q),
                                     rd_en && rd_addr == PMICF_ADDR_UPDOWN);
        end
    end

    // ***********************************
    // mask registers, written by the host
    // ***********************************
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            thm_mask_q <= PMICF_THM_MASK_RST;
            rl_mask_q  <= PMICF_REG_MASK_RST;
            rh_mask_q  <= PMICF_REG_MASK_RST;
            ud_mask_q  <= PMICF_UD_MASK_RST;
        end
        else if (wr_en)
        begin
            case (wr_addr)
                PMICF_ADDR_THM_MASK: thm_mask_q <= wr_data & PMICF_THM_FIELD;
                PMICF_ADDR_RL_MASK:  rl_mask_q  <= wr_data;
                PMICF_ADDR_RH_MASK:  rh_mask_q  <= wr_data;
                PMICF_ADDR_UD_MASK:  ud_mask_q  <= wr_data & PMICF_UD_FIELD;
                default:             thm_mask_q <= thm_mask_q;
            endcase
        end
    end

    // ***********************************
    // source summary
    // ***********************************
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            summary_q <= PMICF_FLAG_RESET;
        else
        begin
            summary_q <= 8'h00;
            summary_q[PMICF_SRC_THERMAL_BIT] <= any_unmasked(thermal_q, thm_mask_q);
            summary_q[PMICF_SRC_REG_BIT]     <= any_unmasked(reg_low_q, rl_mask_q)
                                              | any_unmasked(reg_high_q, rh_mask_q);
            summary_q[PMICF_SRC_UPDOWN_BIT]  <= any_unmasked(updown_q, ud_mask_q);
        end
    end

    assign interrupt_source_summary_o = summary_q;

    // ***********************************
    // read data; unmapped offsets read zero
    // ***********************************
    always_comb
    begin
        case (rd_addr)
            PMICF_ADDR_SOURCE:   rd_data = summary_q;
            PMICF_ADDR_THERMAL:  rd_data = thermal_q & PMICF_THM_FIELD;
            PMICF_ADDR_REG_LOW:  rd_data = reg_low_q;
            PMICF_ADDR_REG_HIGH: rd_data = reg_high_q;
            PMICF_ADDR_UPDOWN:   rd_data = updown_q & PMICF_UD_FIELD;
            PMICF_ADDR_THM_MASK: rd_data = thm_mask_q;
            PMICF_ADDR_RL_MASK:  rd_data = rl_mask_q;
            PMICF_ADDR_RH_MASK:  rd_data = rh_mask_q;
            PMICF_ADDR_UD_MASK:  rd_data = ud_mask_q;
            default:             rd_data = 8'h00;
        endcase
    end
endmodule

// ---- pmicf_flags_checker.sv ----
// port assertions for the interrupt flag block
`timescale 1ns/1ns
module pmicf_flags_checker (
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    input wire logic        scl_i,
    input wire logic        sda_i,
    input wire logic        sda_o,
    input wire logic        sda_oe_o,
    input wire logic        over_temp_warning_i,
    input wire logic        over_temp_critical_i,
    input wire logic [14:0] linear_reg_power_good_i,
    input wire logic        step_down_power_good_i,
    input wire logic        updown_power_good_i,
    input wire logic        updown_overvoltage_i,
    input wire logic        updown_overcurrent_i,
    input wire logic [7:0]  interrupt_source_summary_o
);
    logic [7:0] src;
    logic [3:0] scl_age_q;
    logic [3:0] thm_age_q;
    logic [3:0] reg_age_q;
    logic [3:0] ud_age_q;
    logic       used_q;
    assign src = interrupt_source_summary_o;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // saturating ages: cycles since the last bus edge or group trigger rise
    function automatic logic [3:0] bump(input logic [3:0] a);
        return (a == 4'hF) ? a : a + 4'h1;
    endfunction
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            scl_age_q <= 4'hF;
            thm_age_q <= 4'hF;
            reg_age_q <= 4'hF;
            ud_age_q  <= 4'hF;
            used_q    <= 1'b0;
        end
        else
        begin
            scl_age_q <= $changed(scl_i) ? 4'h0 : bump(scl_age_q);
            thm_age_q <= ($rose(over_temp_warning_i) || $rose(over_temp_critical_i)) ? 4'h0 : bump(thm_age_q);
            reg_age_q <= (|(linear_reg_power_good_i & ~$past(linear_reg_power_good_i))
                         || $rose(step_down_power_good_i)) ? 4'h0 : bump(reg_age_q);
            ud_age_q  <= ($rose(updown_power_good_i) || $rose(updown_overvoltage_i)
                         || $rose(updown_overcurrent_i)) ? 4'h0 : bump(ud_age_q);
            used_q    <= used_q | $fell(scl_i);
        end
    end
    // ****************
    // assertions
    // ****************
    property p_reserved_zero;
        src[7:3] == 5'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("summary reserved bits set");
    property p_quiet_after_reset;
        !used_q |-> src == 8'h00;
    endproperty
    a_quiet_after_reset: assert property (p_quiet_after_reset) else $error("summary set under reset masks");
    property p_thermal_cause;
        $rose(src[0]) |-> (thm_age_q <= 4'h6) || (scl_age_q <= 4'h6);
    endproperty
    a_thermal_cause: assert property (p_thermal_cause) else $error("thermal summary rose without cause");
    property p_reg_cause;
        $rose(src[1]) |-> (reg_age_q <= 4'h6) || (scl_age_q <= 4'h6);
    endproperty
    a_reg_cause: assert property (p_reg_cause) else $error("regulator summary rose without cause");
    property p_updown_cause;
        $rose(src[2]) |-> (ud_age_q <= 4'h6) || (scl_age_q <= 4'h6);
    endproperty
    a_updown_cause: assert property (p_updown_cause) else $error("buck-boost summary rose without cause");
    property p_clear_on_bus;
        |($past(src[2:0]) & ~src[2:0]) |-> scl_age_q <= 4'h6;
    endproperty
    a_clear_on_bus: assert property (p_clear_on_bus) else $error("summary fell away from bus traffic");
    property p_open_drain;
        sda_o == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("data line driven high");
    property p_steady_scl_high;
        scl_i && $past(scl_i) |-> $stable(sda_oe_o);
    endproperty
    a_steady_scl_high: assert property (p_steady_scl_high) else $error("data drive changed with clock high");
endmodule

bind pmicf_flags pmicf_flags_checker checker_i (.core_clk_i, .rst_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
    .over_temp_warning_i, .over_temp_critical_i, .linear_reg_power_good_i, .step_down_power_good_i,
    .updown_power_good_i, .updown_overvoltage_i, .updown_overcurrent_i, .interrupt_source_summary_o);

// ---- pmicf_host.sv ----
// serial host model that reads and writes the flag registers
`timescale 1ns/1ns
module pmicf_host (
    input  wire logic core_clk_i,
    input  wire logic sda_oe_i,
    output logic      scl_o,
    output logic      sda_o
);
    import pmicf_pkg::*;
    logic sda_q;
    // pulled-up wire: high unless some party pulls it low
    assign sda_o = sda_q & ~sda_oe_i;
    initial
    begin
        scl_o = 1'b1;
        sda_q = 1'b1;
    end
    // ****************
    // bus cycles
    // ****************
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    task automatic bit_io(input logic b, output logic r);
        scl_o <= 1'b0;
        tick(4);
        sda_q <= b;
        tick(4);
        scl_o <= 1'b1;
        tick(2);
        r = sda_o;
        tick(2);
    endtask
    // start with (1,0), stop with (0,1)
    task automatic cond(input logic a, input logic b);
        scl_o <= 1'b0;
        tick(4);
        sda_q <= a;
        tick(4);
        scl_o <= 1'b1;
        tick(4);
        sda_q <= b;
        tick(4);
    endtask
    task automatic byte_io(input logic [7:0] d, input logic ack, output logic [7:0] q, output logic got);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(ack, got);
    endtask
    task automatic read_reg(input logic [7:0] a, input int n, output logic [79:0] v, output logic ok);
        logic [7:0] q;
        logic       g0;
        logic       g1;
        logic       g2;
        cond(1'b1, 1'b0);
        byte_io({PMICF_DEV_ADDR, 1'b0}, 1'b1, q, g0);
        byte_io(a, 1'b1, q, g1);
        cond(1'b1, 1'b0);
        byte_io({PMICF_DEV_ADDR, 1'b1}, 1'b1, q, g2);
        ok = !(g0 | g1 | g2);
        v = '0;
        for (int k = 0; k < n; k++)
        begin
            byte_io(8'hFF, k == n - 1, q, g0); // reading is how events are acknowledged
            v[8 * k +: 8] = q;
        end
        cond(1'b0, 1'b1);
    endtask
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic       g0;
        logic       g1;
        logic       g2;
        cond(1'b1, 1'b0);
        byte_io({PMICF_DEV_ADDR, 1'b0}, 1'b1, q, g0);
        byte_io(a, 1'b1, q, g1);
        byte_io(d, 1'b1, q, g2);
        cond(1'b0, 1'b1);
        ok = !(g0 | g1 | g2);
    endtask
    task automatic probe(input logic [6:0] dev, output logic got);
        logic [7:0] q;
        cond(1'b1, 1'b0);
        byte_io({dev, 1'b0}, 1'b1, q, got);
        cond(1'b0, 1'b1);
    endtask
endmodule

// ---- tb.sv ----
// self-checking bench for the interrupt flag block
`timescale 1ns/1ns
module tb;
    import pmicf_pkg::*;
    logic        core_clk_i;
    logic        rst_i;
    logic        scl_i;
    logic        sda_i;
    logic        sda_o;
    logic        sda_oe_o;
    logic [20:0] ev_q;
    logic [7:0]  interrupt_source_summary_o;
    int          err_total;
    int          samples_checked;
    pmicf_host host (.core_clk_i, .sda_oe_i(sda_oe_o), .scl_o(scl_i), .sda_o(sda_i));
    pmicf_flags dut (.core_clk_i, .rst_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
        .over_temp_warning_i(ev_q[0]), .over_temp_critical_i(ev_q[1]), .linear_reg_power_good_i(ev_q[16:2]),
        .step_down_power_good_i(ev_q[17]), .updown_power_good_i(ev_q[18]), .updown_overvoltage_i(ev_q[19]),
        .updown_overcurrent_i(ev_q[20]), .interrupt_source_summary_o);
    always #10 core_clk_i = ~core_clk_i;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic fire(input int i);
        ev_q[i] <= 1'b1;
        host.tick(4);
        ev_q[i] <= 1'b0;
        host.tick(8);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [79:0] v;
        logic        ok;
        host.read_reg(a, 1, v, ok);
        check({7'h00, ok}, 8'h01, "read ack");
        check(v[7:0], exp, what);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        host.write_reg(a, d, ok);
        check({7'h00, ok}, 8'h01, "write ack");
    endtask
    // trigger, see the summary, read and clear, see both drop
    task automatic round(input int i, input logic [7:0] a, input logic [7:0] exp, input int sb);
        fire(i);
        check(interrupt_source_summary_o, 8'h01 << sb, "summary set");
        rd(a, exp, "flags");
        check(interrupt_source_summary_o, 8'h00, "summary cleared");
        rd(a, 8'h00, "flags cleared");
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_reset();
        logic [79:0] v;
        logic [79:0] exp;
        logic        ok;
        exp = 80'h07FFFF03000000000000;
        host.read_reg(PMICF_ADDR_SOURCE, 10, v, ok);
        check({7'h00, ok}, 8'h01, "burst ack");
        for (int k = 0; k < 10; k++)
            check(v[8 * k +: 8], exp[8 * k +: 8], "reset value");
        $display("test reset values done");
    endtask
    task automatic t_thermal();
        fire(0);
        check(interrupt_source_summary_o, 8'h00, "masked summary");
        rd(PMICF_ADDR_THERMAL, 8'h02, "masked flag");
        wr(PMICF_ADDR_THM_MASK, 8'h00);
        round(0, PMICF_ADDR_THERMAL, 8'h02, 0);
        round(1, PMICF_ADDR_THERMAL, 8'h01, 0);
        $display("test thermal done");
    endtask
    task automatic t_regulators();
        int b;
        wr(PMICF_ADDR_RL_MASK, 8'h00);
        wr(PMICF_ADDR_RH_MASK, 8'h00);
        for (int i = 2; i < 18; i++)
        begin
            b = (i < 10) ? i - 2 : i - 10;
            round(i, (i < 10) ? PMICF_ADDR_REG_LOW : PMICF_ADDR_REG_HIGH, 8'h01 << b, 1);
        end
        $display("test regulators done");
    endtask
    task automatic t_updown();
        wr(PMICF_ADDR_UD_MASK, 8'h00);
        for (int i = 18; i < 21; i++)
            round(i, PMICF_ADDR_UPDOWN, 8'h04 >> (i - 18), 2);
        $display("test buck-boost done");
    endtask
    task automatic t_refused();
        logic nack;
        logic ok;
        host.probe(PMICF_DEV_ADDR ^ 7'h01, nack);
        check({7'h00, nack}, 8'h01, "foreign address");
        host.write_reg(PMICF_ADDR_THERMAL, 8'hFF, ok);
        check({7'h00, ok}, 8'h01, "flag write ack");
        rd(PMICF_ADDR_THERMAL, 8'h00, "flag write ignored");
        wr(PMICF_ADDR_THM_MASK, 8'hFF);
        rd(PMICF_ADDR_THM_MASK, 8'h03, "thermal mask field");
        $display("test refusals done");
    endtask
    initial
    begin
        core_clk_i = 1'b0;
        rst_i = 1'b1;
        ev_q = '0;
        err_total = 0;
        samples_checked = 0;
        repeat (8) @(posedge core_clk_i);
        rst_i <= 1'b0;
        host.tick(4);
        t_reset();
        t_thermal();
        t_regulators();
        t_updown();
        t_refused();
        close_out();
    end
    // about 2.3 times the expected run length of some 25600 cycles
    initial
    begin
        repeat (60000) @(posedge core_clk_i);
        err_total++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        close_out();
    end
endmodule
